// *** pulse_timer_pkg.sv ***
// shared constants, register map and state types of the timed pulse functions
package pulse_timer_pkg;
    // ==========================================================
    // widths and timing
    localparam int          TW            = 16;     // interval and elapsed time width
    localparam int          CLK_PERIOD_NS = 10;     // hclk period
    localparam int          TICK_NS       = 1000;   // default timebase tick
    localparam logic [15:0] DIV_RST       = 16'(TICK_NS / CLK_PERIOD_NS - 1);
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] A_CTRL       = 8'h00;
    localparam logic [7:0] A_TBASE      = 8'h04;
    localparam logic [7:0] A_ET_HIGH    = 8'h08;
    localparam logic [7:0] A_ET_LOW     = 8'h0c;
    localparam logic [7:0] A_ET_CYCLES  = 8'h10;
    localparam logic [7:0] A_AP_HIGH    = 8'h14;
    localparam logic [7:0] A_AP_LOW     = 8'h18;
    localparam logic [7:0] A_RG_HIGH    = 8'h1c;
    localparam logic [7:0] A_RG_LOW     = 8'h20;
    localparam logic [7:0] A_SRC        = 8'h24;
    localparam logic [7:0] A_STATUS     = 8'h28;
    localparam logic [7:0] A_ET_ELAPSED = 8'h2c;
    localparam logic [7:0] A_AP_ELAPSED = 8'h30;
    localparam logic [7:0] A_RG_ELAPSED = 8'h34;
    // ==========================================================
    // fields and reset values
    localparam int          CTRL_RESTART = 8;       // write 1: power-loss restart
    localparam int          SRC_W        = 3;       // per interval: live flag + index
    localparam int          SRC_LIVE     = 2;
    localparam int          HTRANS_SEQ   = 1;       // nonseq/seq bit of htrans
    localparam logic [15:0] TIME_RST     = 16'h000a;
    localparam logic [3:0]  CYC_MIN      = 4'h1;
    localparam logic [3:0]  CYC_MAX      = 4'h9;
    localparam logic [15:0] LFSR_SEED    = 16'hace1;
    // pin positions in the synchronised input word
    localparam int PIN_TRG = 0, PIN_CLR = 1, PIN_PGATE = 2, PIN_INV = 3, PIN_RGATE = 4;
    localparam int NPINS   = 5;
    // ==========================================================
    // state types
    typedef enum logic [2:0] {ET_IDLE = 3'b001, ET_LOW = 3'b010, ET_HIGH = 3'b100} et_state_t;
    typedef enum logic [2:0] {AP_OFF = 3'b001, AP_HI = 3'b010, AP_LO = 3'b100} ap_state_t;
    typedef enum logic [2:0] {RG_IDLE = 3'b001, RG_ON = 3'b010, RG_OFF = 3'b100} rg_state_t;
endpackage

// *** timing_if.sv ***
// carrier of the timebase tick and synchronised pins between the timer modules
`timescale 1ns/1ps
interface timing_if #(parameter int W = 5);
    logic         tick;     // one-cycle timebase pulse
    logic [W-1:0] pins;     // pins after two flip-flops
    modport tick_src (output tick);
    modport pin_src  (output pins);
    modport sink     (input tick, input pins);
endinterface

// *** pin_sync.sv ***
// two-flop synchroniser for the digital input pins
`timescale 1ns/1ps
module pin_sync
#(
    parameter int W = 5
)
(
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // raw pins
    input  wire logic [W-1:0] raw,
    // synchronised side
    timing_if.pin_src         sync
);
    // ==========================================================
    // synchroniser
    logic [W-1:0] meta;     // first stage, read only by second stage
    logic [W-1:0] stable;   // second stage

    // pins are asynchronous to hclk, so two stages before any logic
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta   <= '0;
            stable <= '0;
        end
        else
        begin
            meta   <= raw;
            stable <= meta;
        end
    end

    assign sync.pins = stable;
endmodule

// *** tick_gen.sv ***
// timebase divider producing one tick every div+1 clocks
`timescale 1ns/1ps
module tick_gen
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // clocks per tick minus one
    input  wire logic [15:0] div,
    // tick out
    timing_if.tick_src       tb
);
    // ==========================================================
    // divider
    logic [15:0] cnt;       // clocks since last tick
    logic        tick;      // registered tick pulse

    // a lowered divider takes effect at once, never a long wrap
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end
        else if (cnt >= div)
        begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    assign tb.tick = tick;
endmodule

// *** pulse_timer.sv ***
// edge-triggered interval relay, gated pulse generator and random delay behind AHB-Lite
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module pulse_timer
    import pulse_timer_pkg::*;
#(
    parameter logic [15:0] TICK_DIV = DIV_RST     // clocks per tick minus one
)
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // digital inputs
    input  wire logic        trigger,
    input  wire logic        clear,
    input  wire logic        pulse_gate,
    input  wire logic        invert,
    input  wire logic        random_gate,
    // function outputs
    output logic             et_q,
    output logic             ap_q,
    output logic             rg_q
);
    // ==========================================================
    // helpers
    // pick a constant or the live elapsed time of block 0..2
    function automatic logic [TW-1:0] pick(input logic [SRC_W-1:0] sel,
                                           input logic [TW-1:0] k, input logic [TW-1:0] e0,
                                           input logic [TW-1:0] e1, input logic [TW-1:0] e2);
        logic [TW-1:0] v;
        v = k;
        if (sel[SRC_LIVE])
        begin
            case (sel[1:0])
                2'h0:    v = e0;
                2'h1:    v = e1;
                2'h2:    v = e2;
                default: v = k;     // index 3 falls back to the constant
            endcase
        end
        return v;
    endfunction

    // random value in 0..lim inclusive
    function automatic logic [TW-1:0] rand_upto(input logic [TW-1:0] r, input logic [TW-1:0] lim);
        logic [TW:0] m;
        m = {1'b0, r} % ({1'b0, lim} + 17'h00001);
        return m[TW-1:0];
    endfunction

    // ==========================================================
    // submodules
    timing_if #(.W(NPINS)) tif ();
    logic [15:0] tbase;     // clocks per tick minus one

    pin_sync #(.W(NPINS)) u_sync
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .raw     ({random_gate, invert, pulse_gate, clear, trigger}),
        .sync    (tif.pin_src)
    );

    tick_gen u_tick
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .div     (tbase),
        .tb      (tif.tick_src)
    );

    logic tick;             // timebase pulse
    logic trg_s, clr_s, pg_s, inv_s, rg_s;
    logic trg_d, rg_d;      // previous samples for edge detection
    assign tick  = tif.tick;
    assign trg_s = tif.pins[PIN_TRG];
    assign clr_s = tif.pins[PIN_CLR];
    assign pg_s  = tif.pins[PIN_PGATE];
    assign inv_s = tif.pins[PIN_INV];
    assign rg_s  = tif.pins[PIN_RGATE];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trg_d <= 1'b0;
            rg_d  <= 1'b0;
        end
        else
        begin
            trg_d <= trg_s;
            rg_d  <= rg_s;
        end
    end
    logic trg_rise, rg_rise, rg_fall;
    assign trg_rise = trg_s & ~trg_d;
    assign rg_rise  = rg_s & ~rg_d;
    assign rg_fall  = ~rg_s & rg_d;

    // ==========================================================
    // ahb-lite slave, zero wait states
    logic          addr_ph;                 // transfer accepted this edge
    logic          wr_pend;                 // write data phase pending
    logic [7:0]    wr_addr;                 // latched write address
    logic [2:0]    retain;                  // per-function retentive option
    logic          restart;                 // one-cycle power-loss restart
    logic [TW-1:0] et_hk, et_lk, ap_hk, ap_lk, rg_hk, rg_lk;    // constant intervals
    logic [3:0]    et_cycles;               // cycles per trigger
    logic [6*SRC_W-1:0] src;                // interval source selects
    logic [TW-1:0] et_el, ap_el, rg_el;     // elapsed_time of each function
    logic [31:0]   rd_val;                  // read mux
    assign addr_ph = hsel & htrans[HTRANS_SEQ] & hready;

    // address phase latch; only the low byte decodes, upper bits alias
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend   <= addr_ph & hwrite;
            wr_addr   <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;  // always okay, unmapped included
        end
    end

    // read data sampled at the address phase so hrdata leaves a flop
    always_comb
    begin
        case (haddr[7:0])
            A_CTRL:       rd_val = {29'h0, retain};
            A_TBASE:      rd_val = {16'h0, tbase};
            A_ET_HIGH:    rd_val = {16'h0, et_hk};
            A_ET_LOW:     rd_val = {16'h0, et_lk};
            A_ET_CYCLES:  rd_val = {28'h0, et_cycles};
            A_AP_HIGH:    rd_val = {16'h0, ap_hk};
            A_AP_LOW:     rd_val = {16'h0, ap_lk};
            A_RG_HIGH:    rd_val = {16'h0, rg_hk};
            A_RG_LOW:     rd_val = {16'h0, rg_lk};
            A_SRC:        rd_val = {14'h0, src};
            A_STATUS:     rd_val = {29'h0, rg_q, ap_q, et_q};
            A_ET_ELAPSED: rd_val = {16'h0, et_el};
            A_AP_ELAPSED: rd_val = {16'h0, ap_el};
            A_RG_ELAPSED: rd_val = {16'h0, rg_el};
            default:      rd_val = 32'h0;       // unmapped reads zero
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (addr_ph && !hwrite)
            hrdata <= rd_val;
    end

    // configuration writes; cycle count clamped into its legal range
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            retain    <= 3'h0;
            tbase     <= TICK_DIV;
            et_hk     <= TIME_RST;
            et_lk     <= TIME_RST;
            ap_hk     <= TIME_RST;
            ap_lk     <= TIME_RST;
            rg_hk     <= TIME_RST;
            rg_lk     <= TIME_RST;
            et_cycles <= CYC_MIN;
            src       <= '0;
            restart   <= 1'b0;
        end
        else
        begin
            restart <= wr_pend && wr_addr == A_CTRL && hwdata[CTRL_RESTART];
            if (wr_pend)
            begin
                case (wr_addr)
                    A_CTRL:      retain <= hwdata[2:0];
                    A_TBASE:     tbase  <= hwdata[15:0];
                    A_ET_HIGH:   et_hk  <= hwdata[15:0];
                    A_ET_LOW:    et_lk  <= hwdata[15:0];
                    A_ET_CYCLES: et_cycles <= (hwdata[31:0] < 32'(CYC_MIN)) ? CYC_MIN :
                                              (hwdata[31:0] > 32'(CYC_MAX)) ? CYC_MAX :
                                              hwdata[3:0];
                    A_AP_HIGH:   ap_hk  <= hwdata[15:0];
                    A_AP_LOW:    ap_lk  <= hwdata[15:0];
                    A_RG_HIGH:   rg_hk  <= hwdata[15:0];
                    A_RG_LOW:    rg_lk  <= hwdata[15:0];
                    A_SRC:       src    <= hwdata[6*SRC_W-1:0];
                    default:     ;                          // read-only or unmapped
                endcase
            end
        end
    end

    // ==========================================================
    // effective intervals, constant or live
    logic [TW-1:0] et_hi, et_lo, ap_hi, ap_lo, rg_hi, rg_lo;
    assign et_hi = pick(src[2:0],   et_hk, et_el, ap_el, rg_el);
    assign et_lo = pick(src[5:3],   et_lk, et_el, ap_el, rg_el);
    assign ap_hi = pick(src[8:6],   ap_hk, et_el, ap_el, rg_el);
    assign ap_lo = pick(src[11:9],  ap_lk, et_el, ap_el, rg_el);
    assign rg_hi = pick(src[14:12], rg_hk, et_el, ap_el, rg_el);
    assign rg_lo = pick(src[17:15], rg_lk, et_el, ap_el, rg_el);

    // ==========================================================
    // edge-triggered interval relay
    et_state_t et_state;
    logic [3:0] et_left;    // cycles still to run
    logic       et_done;    // current phase reaches its interval on this tick
    assign et_done = tick && (et_el + 16'h0001 >= (et_state == ET_LOW ? et_lo : et_hi));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            et_state <= ET_IDLE;
            et_el    <= '0;
            et_left  <= 4'h0;
            et_q     <= 1'b0;
        end
        else if (clr_s || (restart && !retain[0]))
        begin
            et_state <= ET_IDLE;
            et_el    <= '0;
            et_q     <= 1'b0;
        end
        else if (trg_rise)
        begin
            et_state <= ET_LOW;
            et_el    <= '0;
            et_left  <= et_cycles;
            et_q     <= 1'b0;
        end
        else
        begin
            case (et_state)
                ET_LOW:
                begin
                    if (et_done)
                    begin
                        et_state <= ET_HIGH;
                        et_el    <= '0;
                        et_q     <= 1'b1;
                    end
                    else if (tick)
                        et_el <= et_el + 16'h0001;
                end
                ET_HIGH:
                begin
                    if (et_done && et_left > 4'h1)
                    begin
                        et_state <= ET_LOW;
                        et_left  <= et_left - 4'h1;
                        et_el    <= '0;
                        et_q     <= 1'b0;
                    end
                    else if (et_done)
                    begin
                        et_state <= ET_IDLE;
                        et_el    <= '0;
                        et_q     <= 1'b0;
                    end
                    else if (tick)
                        et_el <= et_el + 16'h0001;
                end
                ET_IDLE: et_q <= 1'b0;
                default: et_state <= ET_IDLE;
            endcase
        end
    end

    // ==========================================================
    // gated pulse generator; output follows state one clock later
    ap_state_t ap_state;
    logic      ap_done;     // current phase ends on this tick
    assign ap_done = tick && (ap_el + 16'h0001 >= (ap_state == AP_HI ? ap_hi : ap_lo));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_state <= AP_OFF;
            ap_el    <= '0;
        end
        else if (!pg_s || (restart && !retain[1]))
        begin
            ap_state <= AP_OFF;
            ap_el    <= '0;
        end
        else
        begin
            case (ap_state)
                AP_OFF: ap_state <= AP_HI;
                AP_HI, AP_LO:
                begin
                    if (ap_done)
                    begin
                        ap_state <= (ap_state == AP_HI) ? AP_LO : AP_HI;
                        ap_el    <= '0;
                    end
                    else if (tick)
                        ap_el <= ap_el + 16'h0001;
                end
                default: ap_state <= AP_OFF;
            endcase
        end
    end

    // inversion applies only while enabled; ungated output is always low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ap_q <= 1'b0;
        else
            ap_q <= pg_s && ((ap_state == AP_HI) ^ inv_s);
    end

    // ==========================================================
    // random delay
    rg_state_t     rg_state;
    logic [TW-1:0] rg_target;   // drawn delay length
    logic [TW-1:0] lfsr;        // free-running random source

    // lfsr runs every clock so draws depend on input timing too
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lfsr <= LFSR_SEED;
        else
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rg_state  <= RG_IDLE;
            rg_el     <= '0;
            rg_target <= '0;
            rg_q      <= 1'b0;
        end
        else if (restart && !retain[2])
        begin
            rg_state <= RG_IDLE;
            rg_el    <= '0;
            rg_q     <= 1'b0;
        end
        else if (rg_rise)
        begin
            rg_state  <= RG_ON;
            rg_el     <= '0;
            rg_target <= rand_upto(lfsr, rg_hi);
        end
        else if (rg_fall)
        begin
            rg_state  <= RG_OFF;
            rg_el     <= '0;
            rg_target <= rand_upto(lfsr, rg_lo);
        end
        else if (tick && rg_state != RG_IDLE)
        begin
            if (rg_el >= rg_target)
            begin
                rg_q     <= (rg_state == RG_ON) && rg_s;
                rg_state <= RG_IDLE;
                rg_el    <= '0;
            end
            else
                rg_el <= rg_el + 16'h0001;
        end
    end

    // ==========================================================
    // checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    et_clear_a: assert property (clr_s |=> !et_q && et_el == '0 && et_state == ET_IDLE)
        else $error("clear did not zero interval relay");
    et_start_a: assert property (trg_rise && !clr_s && !restart |=>
        et_state == ET_LOW && et_el == '0 && !et_q && et_left == $past(et_cycles))
        else $error("trigger did not start low interval");
    et_high_a: assert property ($rose(et_q) |-> et_state == ET_HIGH && $past(et_state) == ET_LOW)
        else $error("output rose outside low to high step");
    et_last_a: assert property (et_state == ET_HIGH && et_done && et_left == 4'h1 &&
        !trg_rise && !clr_s && !restart |=> et_state == ET_IDLE ##1 !et_q)
        else $error("relay not idle after last cycle");
    et_count_a: assert property (et_cycles >= CYC_MIN && et_cycles <= CYC_MAX)
        else $error("cycle count out of range");
    et_tick_a: assert property (et_state == ET_LOW && !tick && !trg_rise && !clr_s &&
        !restart |=> $stable(et_el))
        else $error("elapsed time moved without a tick");
    // gate and invert may rise together, so ap_q is judged on the edge after the gate is low
    ap_off_a: assert property (!pg_s |=> ap_state == AP_OFF && !ap_q)
        else $error("ungated generator not off");
    ap_inv_a: assert property (##1 ap_q == ($past(pg_s) &&
        (($past(ap_state) == AP_HI) ^ $past(inv_s))))
        else $error("pulse generator polarity wrong");
    ap_restart_a: assert property ($rose(pg_s) |=> ap_state == AP_HI)
        else $error("generator did not start on high interval");
    rg_on_a: assert property (rg_state == RG_ON && tick && rg_el >= rg_target && rg_s &&
        !restart && !rg_fall |=> rg_q)
        else $error("random on-delay did not set output");
    rg_abandon_a: assert property (rg_fall && !restart |=> rg_state == RG_OFF &&
        rg_target <= $past(rg_lo))
        else $error("gate fall did not abandon on-delay");
    rg_draw_a: assert property (rg_rise && !restart |=> rg_state == RG_ON &&
        rg_target <= $past(rg_hi))
        else $error("random on-delay out of range");

    et_burst_c: cover property ($fell(et_q) && et_state == ET_LOW);
    et_retrig_c: cover property (trg_rise && et_state == ET_HIGH);
    ap_inv_c: cover property (pg_s && inv_s && $rose(ap_q));
    rg_on_c: cover property ($rose(rg_q));
endmodule

// *** pin_model.sv ***
// digital pin driver standing in for the switches wired to the module
`timescale 1ns/1ps
module pin_model
(
    // clock
    input  wire logic       hclk,
    // wanted levels {random_gate,invert,pulse_gate,clear,trigger}
    input  wire logic [4:0] lv,
    // pins
    output logic      [4:0] pins
);
    // ==========================================================
    // switches change just after an edge, like an unsynchronised field input
    // single driver; the synchroniser sits in reset until the first edge has set the pins
    always @(posedge hclk) pins <= lv;
endmodule

// *** pulse_timer_test.sv ***
// register and pin tests of the timed pulse functions
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module pulse_timer_test;
    import pulse_timer_pkg::*;
    // ==========================================================
    // bus, pins and tallies
    logic        hclk = 0, hresetn = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0]  htrans = 0;
    logic [4:0]  lv = 0, pins;
    logic        et_q, ap_q, rg_q, et_d = 0, ap_d = 0, hresp;
    int          bad_count = 0, n_tests = 0, et_n = 0, et_r = 0, ap_r = 0, wd = 0;
    // tally snapshots; the tallies have one writer, so windows are taken as differences
    int          b_n = 0, b_r = 0, b_a = 0;
    initial forever #5 hclk = ~hclk;
    pin_model pm_u (.hclk(hclk), .lv(lv), .pins(pins));
    pulse_timer #(.TICK_DIV(16'h0000)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .trigger(pins[0]), .clear(pins[1]), .pulse_gate(pins[2]), .invert(pins[3]),
        .random_gate(pins[4]), .et_q(et_q), .ap_q(ap_q), .rg_q(rg_q));
    // ==========================================================
    // output tallies; a rise count catches both lost and extra pulses
    always @(posedge hclk)
    begin
        et_d <= et_q;
        ap_d <= ap_q;
        et_n <= et_n + int'(et_q);
        et_r <= et_r + int'(et_q & ~et_d);
        ap_r <= ap_r + int'(ap_q & ~ap_d);
        wd   <= wd + 1;
        if (wd == 20000) begin bad_count++; wrap_up(); end
    end
    // single ahb-lite transfer, waits on hready each phase
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h000000, a}; hwrite <= w; htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task pin(input logic [4:0] v, input int n);
        lv <= v;
        repeat (n) @(posedge hclk);
    endtask
    task wrap_up();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(A_ET_CYCLES, 0, 0); `CHK(r, 32'(CYC_MIN))
        bus(A_AP_HIGH, 0, 0); `CHK(r, 32'(TIME_RST))
        bus(8'h3c, 0, 0); `CHK(r, 32'h0)
        `CHK(hresp, 1'b0)
        bus(A_ET_CYCLES, 1, 0); bus(A_ET_CYCLES, 0, 0); `CHK(r, 32'h1)
        bus(A_ET_CYCLES, 1, 15); bus(A_ET_CYCLES, 0, 0); `CHK(r, 32'h9)
        $display("test registers done");
        bus(A_TBASE, 1, 0); bus(A_ET_HIGH, 1, 3); bus(A_ET_LOW, 1, 2);
        bus(A_ET_CYCLES, 1, 2);
        // retrigger lands in the second high phase; window opens once it has acted
        pin(5'h01, 2); pin(5'h00, 6); pin(5'h01, 2); pin(5'h00, 3);
        b_n = et_n; b_r = et_r; pin(5'h00, 37);
        `CHK(et_n - b_n, 6)
        `CHK(et_r - b_r, 2)
        `CHK(et_q, 1'b0)
        // clear arrives while the output is high
        pin(5'h01, 3); pin(5'h02, 5); `CHK(et_q, 1'b0)
        bus(A_ET_ELAPSED, 0, 0); `CHK(r, 32'h0)
        pin(5'h00, 2);
        // power-loss restart: non-retentive relay drops its elapsed time, retentive keeps it
        bus(A_ET_LOW, 1, 100); pin(5'h01, 20);
        bus(A_CTRL, 1, 32'h100); bus(A_ET_ELAPSED, 0, 0); `CHK(r, 32'h0)
        pin(5'h00, 4); pin(5'h01, 20);
        bus(A_CTRL, 1, 32'h101); bus(A_ET_ELAPSED, 0, 0); `CHK(r == 32'h0, 1'b0)
        pin(5'h02, 4); pin(5'h00, 2);
        $display("test relay done");
        bus(A_AP_HIGH, 1, 2); bus(A_AP_LOW, 1, 2);
        pin(5'h08, 8); `CHK(ap_q, 1'b0)
        pin(5'h04, 8); b_a = ap_r; pin(5'h04, 40); `CHK(ap_r - b_a, 10)
        pin(5'h0c, 8); b_a = ap_r; pin(5'h0c, 40); `CHK(ap_r - b_a, 10)
        pin(5'h00, 8); `CHK(ap_q, 1'b0)
        $display("test generator done");
        bus(A_RG_HIGH, 1, 0); bus(A_RG_LOW, 1, 0);
        pin(5'h10, 10); `CHK(rg_q, 1'b1)
        pin(5'h00, 10); `CHK(rg_q, 1'b0)
        bus(A_STATUS, 0, 0); `CHK(r, 32'h0)
        $display("test random done");
        wrap_up();
    end
endmodule
